// ### design/rss_top.sv
// Local design decisions: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "rss_defs.svh"

module rss_top #(
  parameter int WDT_W = 32,
  parameter int BUZZ_W = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic initial_supply_reset,
  input wire logic supply_ramping,
  input wire rss_pkg::rss_trip_s trip,
  input wire rss_pkg::rss_pmode_e power_mode,
  input wire logic external_reset_pin_n,
  output logic external_pin_pullup,
  output logic system_reset,
  output rss_pkg::rss_mon_en_s mon_en,
  output logic [3:0] analog_lv_level,
  output logic [3:0] core_lv_level,
  output logic wake_req,
  output logic supply_irq,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import rss_pkg::*;

  // ----------------------------------------
  // Helpers.
  // ----------------------------------------
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'h0) && (a <= `RSS_STATE_OFF);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = n[i*8 +: 8];
      end
    end
    merge = r;
  endfunction

  // ----------------------------------------
  // State.
  // ----------------------------------------
  logic aw_hold_ff, w_hold_ff, awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [7:0] waddr_ff;
  logic [31:0] wdata_ff, rdata_ff;
  logic [3:0] wstrb_ff;
  logic [7:0] ctrl_ff, level_ff;
  logic wdt_en_ff;
  logic [WDT_W-1:0] wdt_to_ff, wdt_cnt_ff;
  logic [BUZZ_W-1:0] buzz_per_ff, buzz_cnt_ff;
  logic [5:0] stat_ff;
  logic software_reset_ff, wdt_fire_ff, boot_done_ff, sys_rst_ff, buzz_ff;
  logic [4:0] hold_cnt_ff;
  rss_mon_en_s mon_en_ff;
  logic wake_req_ff, irq_ff, pullup_ff;

  logic do_wr, aw_go, w_go, ar_go;
  logic initial_supply_reset_act, precise_undervolt_reset_act, external_reset_pin_act, lvi_rst, src_any, por_clr;
  logic [2:0] lv_ev;
  logic [5:0] stat_set, stat_clr;
  logic [31:0] rd_mux;

  assign aw_go = s_axi_awvalid && awready_ff;
  assign w_go = s_axi_wvalid && wready_ff;
  assign ar_go = s_axi_arvalid && arready_ff;
  assign do_wr = aw_hold_ff && w_hold_ff && !bvalid_ff;

  // ----------------------------------------
  // Reset sources and merge.
  // ----------------------------------------
  assign initial_supply_reset_act = !boot_done_ff && (initial_supply_reset || supply_ramping);
  assign precise_undervolt_reset_act = mon_en_ff.precise_dig_en && trip.precise_dig
                 || mon_en_ff.precise_ana_en && trip.precise_ana;
  assign external_reset_pin_act = !external_reset_pin_n;
  assign lv_ev[0] = mon_en_ff.lv_mon_en && trip.analog_lv;
  assign lv_ev[1] = mon_en_ff.lv_mon_en && trip.core_lv;
  assign lv_ev[2] = mon_en_ff.lv_mon_en && trip.analog_hv;
  assign lvi_rst = lv_ev[0] && ctrl_ff[`RSS_B_ALVRST]
                || lv_ev[1] && ctrl_ff[`RSS_B_CLVRST];
  assign src_any = initial_supply_reset_act || precise_undervolt_reset_act || external_reset_pin_act || software_reset_ff || wdt_fire_ff
                || lvi_rst;
  assign por_clr = !aresetn || initial_supply_reset_act || precise_undervolt_reset_act;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hold_cnt_ff <= 5'(`RSS_RST_MIN_CYC);
      sys_rst_ff <= 1'b1;
    end else if (src_any) begin
      hold_cnt_ff <= 5'(`RSS_RST_MIN_CYC);
      sys_rst_ff <= 1'b1;
    end else begin
      if (hold_cnt_ff != 5'h00) begin
        hold_cnt_ff <= hold_cnt_ff - 5'h01;
      end
      sys_rst_ff <= (hold_cnt_ff > 5'h01);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      boot_done_ff <= 1'b0;
    end else if (!sys_rst_ff) begin
      boot_done_ff <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pullup_ff <= 1'b1;
    end else begin
      pullup_ff <= 1'b1;
    end
  end

  // ----------------------------------------
  // Monitor enables and sleep buzz.
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn || power_mode != RSS_SLEEP) begin
      buzz_cnt_ff <= '0;
      buzz_ff <= 1'b0;
    end else begin
      buzz_cnt_ff <= (buzz_cnt_ff >= buzz_per_ff) ? '0 : buzz_cnt_ff + 1'b1;
      buzz_ff <= (buzz_cnt_ff < BUZZ_W'(`RSS_BUZZ_ON_CYC));
    end
  end

  logic mon_on;
  assign mon_on = boot_done_ff && (power_mode == RSS_ACTIVE
                                   || power_mode == RSS_SLEEP && buzz_ff);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mon_en_ff <= '0;
    end else begin
      mon_en_ff.initial_mon_en <= !boot_done_ff;
      mon_en_ff.precise_dig_en <= mon_on;
      mon_en_ff.precise_ana_en <= mon_on && ctrl_ff[`RSS_B_ANAREG];
      mon_en_ff.lv_mon_en <= mon_on;
    end
  end

  // ----------------------------------------
  // Supply interrupt and wakeup.
  // ----------------------------------------
  logic irq_pend;
  assign irq_pend = stat_ff[`RSS_S_ALV] && ctrl_ff[`RSS_B_ALVIE]
                 || stat_ff[`RSS_S_CLV] && ctrl_ff[`RSS_B_CLVIE]
                 || stat_ff[`RSS_S_AHV] && ctrl_ff[`RSS_B_AHVIE];

  always_ff @(posedge aclk) begin
    if (!aresetn || sys_rst_ff) begin
      wake_req_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else begin
      wake_req_ff <= irq_pend && power_mode != RSS_ACTIVE;
      irq_ff <= irq_pend && power_mode == RSS_ACTIVE;
    end
  end

  // ----------------------------------------
  // Status register.
  // ----------------------------------------
  assign stat_set[`RSS_S_EXT] = external_reset_pin_act;
  assign stat_set[`RSS_S_SW] = software_reset_ff;
  assign stat_set[`RSS_S_WDT] = wdt_fire_ff;
  assign stat_set[`RSS_S_ALV] = lv_ev[0];
  assign stat_set[`RSS_S_CLV] = lv_ev[1];
  assign stat_set[`RSS_S_AHV] = lv_ev[2];
  assign stat_clr = (do_wr && waddr_ff == `RSS_STAT_OFF && wstrb_ff[0]) ? wdata_ff[5:0]
                                                                        : 6'h00;

  always_ff @(posedge aclk) begin
    if (por_clr) begin
      stat_ff <= 6'h00;
    end else begin
      stat_ff <= (stat_ff & ~stat_clr) | stat_set;
    end
  end

  // ----------------------------------------
  // Control registers.
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn || sys_rst_ff) begin
      ctrl_ff <= `RSS_CTRL_RST;
      level_ff <= `RSS_LEVEL_RST;
      wdt_to_ff <= WDT_W'(`RSS_WDTO_RST);
      buzz_per_ff <= BUZZ_W'(`RSS_BUZZ_RST);
    end else if (do_wr) begin
      if (waddr_ff == `RSS_CTRL_OFF && wstrb_ff[0]) begin
        ctrl_ff <= wdata_ff[7:0];
      end
      if (waddr_ff == `RSS_LEVEL_OFF && wstrb_ff[0]) begin
        level_ff <= wdata_ff[7:0];
      end
      if (waddr_ff == `RSS_WDTO_OFF) begin
        wdt_to_ff <= WDT_W'(merge(32'(wdt_to_ff), wdata_ff, wstrb_ff));
      end
      if (waddr_ff == `RSS_BUZZ_OFF) begin
        buzz_per_ff <= BUZZ_W'(merge(32'(buzz_per_ff), wdata_ff, wstrb_ff));
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || sys_rst_ff) begin
      software_reset_ff <= 1'b0;
    end else begin
      software_reset_ff <= do_wr && waddr_ff == `RSS_SWRST_OFF && wstrb_ff[0] && wdata_ff[0]
              && !ctrl_ff[`RSS_B_SWDIS];
    end
  end

  // ----------------------------------------
  // Watchdog.
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn || initial_supply_reset_act) begin
      wdt_en_ff <= 1'b0;
    end else if (do_wr && waddr_ff == `RSS_CTRL_OFF && wstrb_ff[0]
                 && wdata_ff[`RSS_B_WDTEN]) begin
      wdt_en_ff <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || sys_rst_ff || !wdt_en_ff) begin
      wdt_cnt_ff <= wdt_to_ff;
      wdt_fire_ff <= 1'b0;
    end else if (do_wr && waddr_ff == `RSS_KICK_OFF) begin
      wdt_cnt_ff <= wdt_to_ff;
      wdt_fire_ff <= 1'b0;
    end else begin
      if (wdt_cnt_ff != '0) begin
        wdt_cnt_ff <= wdt_cnt_ff - 1'b1;
      end
      wdt_fire_ff <= (wdt_cnt_ff == '0);
    end
  end

  // ----------------------------------------
  // AXI4-Lite write channel.
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_ff <= 1'b0;
      awready_ff <= 1'b0;
      waddr_ff <= 8'h00;
    end else if (s_axi_bvalid && s_axi_bready) begin
      aw_hold_ff <= 1'b0;
      awready_ff <= 1'b1;
    end else if (aw_go) begin
      aw_hold_ff <= 1'b1;
      awready_ff <= 1'b0;
      waddr_ff <= s_axi_awaddr;
    end else if (!aw_hold_ff) begin
      awready_ff <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_hold_ff <= 1'b0;
      wready_ff <= 1'b0;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      w_hold_ff <= 1'b0;
      wready_ff <= 1'b1;
    end else if (w_go) begin
      w_hold_ff <= 1'b1;
      wready_ff <= 1'b0;
      wdata_ff <= s_axi_wdata;
      wstrb_ff <= s_axi_wstrb;
    end else if (!w_hold_ff) begin
      wready_ff <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= 2'h0;
    end else if (do_wr) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= mapped(waddr_ff) ? 2'h0 : 2'h2;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  // ----------------------------------------
  // AXI4-Lite read channel.
  // ----------------------------------------
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (s_axi_araddr)
      `RSS_CTRL_OFF: rd_mux = {24'h0, ctrl_ff[7:3], wdt_en_ff, ctrl_ff[1:0]};
      `RSS_LEVEL_OFF: rd_mux = {24'h0, level_ff};
      `RSS_WDTO_OFF: rd_mux = 32'(wdt_to_ff);
      `RSS_KICK_OFF: rd_mux = 32'(wdt_cnt_ff);
      `RSS_BUZZ_OFF: rd_mux = 32'(buzz_per_ff);
      `RSS_STAT_OFF: rd_mux = {26'h0, stat_ff};
      `RSS_STATE_OFF: rd_mux = {26'h0, irq_ff, wake_req_ff, buzz_ff,
                                mon_en_ff.lv_mon_en, mon_en_ff.precise_dig_en,
                                boot_done_ff};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= 2'h0;
    end else if (ar_go) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b1;
      rdata_ff <= rd_mux;
      rresp_ff <= mapped(s_axi_araddr) ? 2'h0 : 2'h2;
    end else if (rvalid_ff && s_axi_rready) begin
      rvalid_ff <= 1'b0;
      arready_ff <= 1'b1;
    end else if (!rvalid_ff) begin
      arready_ff <= 1'b1;
    end
  end

  // ----------------------------------------
  // Outputs.
  // ----------------------------------------
  assign external_pin_pullup = pullup_ff;
  assign system_reset = sys_rst_ff;
  assign mon_en = mon_en_ff;
  assign analog_lv_level = level_ff[3:0];
  assign core_lv_level = level_ff[7:4];
  assign wake_req = wake_req_ff;
  assign supply_irq = irq_ff;
  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

endmodule // rss_top

// ### design/rss_defs.svh
`ifndef RSS_DEFS_SVH
`define RSS_DEFS_SVH

`define RSS_CTRL_OFF 8'h00
`define RSS_LEVEL_OFF 8'h04
`define RSS_SWRST_OFF 8'h08
`define RSS_WDTO_OFF 8'h0C
`define RSS_KICK_OFF 8'h10
`define RSS_BUZZ_OFF 8'h14
`define RSS_STAT_OFF 8'h18
`define RSS_STATE_OFF 8'h1C

`define RSS_CTRL_RST 8'h01
`define RSS_LEVEL_RST 8'h00
`define RSS_WDTO_RST 32'h0001_0000
`define RSS_BUZZ_RST 16'h0400

`define RSS_B_ANAREG 0
`define RSS_B_SWDIS 1
`define RSS_B_WDTEN 2
`define RSS_B_ALVIE 3
`define RSS_B_CLVIE 4
`define RSS_B_AHVIE 5
`define RSS_B_ALVRST 6
`define RSS_B_CLVRST 7

`define RSS_S_EXT 0
`define RSS_S_SW 1
`define RSS_S_WDT 2
`define RSS_S_ALV 3
`define RSS_S_CLV 4
`define RSS_S_AHV 5

`define RSS_CLK_NS 8
`define RSS_RST_MIN_NS 150
`define RSS_RST_MIN_CYC ((`RSS_RST_MIN_NS + `RSS_CLK_NS - 1) / `RSS_CLK_NS)
`define RSS_BUZZ_ON_CYC 16'h0004
`endif

// ### design/rss_pkg.sv
package rss_pkg;

  typedef enum logic [1:0] {
    RSS_ACTIVE,
    RSS_SLEEP,
    RSS_HIBERNATE
  } rss_pmode_e;

  typedef struct packed {
    logic precise_dig;
    logic precise_ana;
    logic analog_lv;
    logic core_lv;
    logic analog_hv;
  } rss_trip_s;

  typedef struct packed {
    logic precise_dig_en;
    logic precise_ana_en;
    logic lv_mon_en;
    logic initial_mon_en;
  } rss_mon_en_s;

endpackage

// ### dv/rss_monitor.sv
`timescale 1ns/10ps
module rss_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire rss_pkg::rss_pmode_e power_mode,
  input wire logic external_reset_pin_n,
  input wire logic external_pin_pullup,
  input wire logic system_reset,
  input wire rss_pkg::rss_mon_en_s mon_en,
  input wire logic wake_req,
  input wire logic supply_irq,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid
);
  import rss_pkg::*;
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking mon_cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  a_pin_holds: assert property (!external_reset_pin_n [*3] |-> system_reset)
    else $error("reset low while pin held low");
  a_pin_stretch: assert property ($fell(system_reset) |-> $past(external_reset_pin_n, 19))
    else $error("reset released too soon after pin");
  a_pullup_on: assert property (1'b1 |=> external_pin_pullup)
    else $error("pin pull-up off");
  a_hib_mon_off: assert property ((power_mode == RSS_HIBERNATE) [*2] |->
    !mon_en.lv_mon_en && !mon_en.precise_dig_en)
    else $error("monitor on in hibernate");
  a_dig_first: assert property (mon_en.precise_ana_en |-> mon_en.precise_dig_en)
    else $error("digital precise monitor off");
  a_irq_active: assert property (supply_irq |-> $past(power_mode) == RSS_ACTIVE)
    else $error("interrupt outside active mode");
  a_wake_asleep: assert property (wake_req |-> $past(power_mode) != RSS_ACTIVE)
    else $error("wake request in active mode");
  a_b_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_r_refuse: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h1C
    |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  c_reset: cover property ($rose(system_reset));
  c_wake: cover property ($rose(wake_req));
  c_irq: cover property ($rose(supply_irq));
endmodule // rss_monitor

bind rss_top rss_monitor mon (.aclk, .aresetn, .power_mode, .external_reset_pin_n,
  .external_pin_pullup, .system_reset, .mon_en, .wake_req, .supply_irq, .s_axi_bvalid,
  .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid);

// ### dv/rss_partner.sv
`timescale 1ns/10ps
module rss_partner #(
  parameter int GUARD = 1250
) (
  input wire logic aclk,
  input wire logic press,
  input wire logic pull_en,
  output logic pin_n
);
  // ------------------------------------------------------------
  // External reset driver
  // ------------------------------------------------------------
  logic low_ff = 1'b0;
  int gap_ff = 0;
  always_ff @(posedge aclk) begin
    if (gap_ff != 0) gap_ff <= gap_ff - 1;
    if (press && gap_ff == 0) low_ff <= 1'b1;
    if (!press && low_ff) begin
      low_ff <= 1'b0;
      gap_ff <= GUARD;
    end
  end
  assign pin_n = !low_ff && pull_en;
endmodule // rss_partner

// ### dv/system_reset_supervisor_bench.sv
`timescale 1ns/10ps
`include "rss_defs.svh"
module system_reset_supervisor_bench;
  import rss_pkg::*;
  logic aclk, aresetn, initial_supply_reset, supply_ramping, press, pin_n, external_pin_pullup;
  logic system_reset, wake_req, supply_irq, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb, analog_lv_level, core_lv_level;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  rss_trip_s trip;
  rss_pmode_e power_mode;
  rss_mon_en_s mon_en;
  int n_errors = 0, comparisons = 0, n;
  rss_top dut (.aclk, .aresetn, .initial_supply_reset, .supply_ramping, .trip, .power_mode,
    .external_reset_pin_n(pin_n), .external_pin_pullup, .system_reset, .mon_en,
    .analog_lv_level, .core_lv_level, .wake_req, .supply_irq, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  rss_partner drv (.aclk, .press, .pull_en(external_pin_pullup), .pin_n);
  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task chk(input string nm, input logic [31:0] e, s);
    comparisons++;
    if (s !== e) begin
      n_errors++;
      $display("[ERR] %s exp %h got %h", nm, e, s);
    end
  endtask
  task wt(input logic v, output int c);
    c = 0;
    while (system_reset !== v && c < 500) begin
      @(posedge aclk);
      c++;
    end
    chk("sysrst", v, system_reset);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
    int t;
    t = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && ++t < 99);
    s_axi_bready <= 1'b0;
    chk("bvalid", 1'h1, s_axi_bvalid);
    chk("bresp", er, s_axi_bresp);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er = 2'h0);
    int t;
    t = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && ++t < 99);
    s_axi_rready <= 1'b0;
    chk("rvalid", 1'h1, s_axi_rvalid);
    chk("rdata", ed, s_axi_rdata);
    chk("rresp", er, s_axi_rresp);
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task t_boot;
    repeat (20) @(posedge aclk);
    supply_ramping <= 1'b0;
    chk("ramp hold", 1'h1, system_reset);
    wt(1'b0, n);
    chk("stretch", 1'h1, n >= 19);
    initial_supply_reset <= 1'b1;
    repeat (5) @(posedge aclk);
    chk("initial ignored", 1'h0, system_reset);
    chk("initial off", 1'h0, mon_en.initial_mon_en);
    initial_supply_reset <= 1'b0;
    rd(`RSS_CTRL_OFF, `RSS_CTRL_RST);
    rd(`RSS_WDTO_OFF, `RSS_WDTO_RST);
    rd(`RSS_BUZZ_OFF, `RSS_BUZZ_RST);
    rd(`RSS_STAT_OFF, 32'h0);
    rd(8'h20, 32'h0, 2'h2);
    wr(8'h22, 32'h1, 2'h2);
    wr(`RSS_CTRL_OFF, 32'h0);
    repeat (3) @(posedge aclk);
    chk("dig kept", 1'h1, mon_en.precise_dig_en);
    chk("ana off", 1'h0, mon_en.precise_ana_en);
    $display("test boot done");
  endtask
  task t_sw;
    wr(`RSS_LEVEL_OFF, 32'hF3);
    chk("alv code", 4'h3, analog_lv_level);
    chk("clv code", 4'hF, core_lv_level);
    wr(`RSS_SWRST_OFF, 32'h1);
    wt(1'b1, n);
    wt(1'b0, n);
    chk("sw stretch", 1'h1, n >= 19);
    rd(`RSS_LEVEL_OFF, `RSS_LEVEL_RST);
    rd(`RSS_CTRL_OFF, `RSS_CTRL_RST);
    rd(`RSS_STAT_OFF, 32'h2);
    wr(`RSS_CTRL_OFF, 32'h3);
    wr(`RSS_SWRST_OFF, 32'h1);
    repeat (5) @(posedge aclk);
    chk("sw blocked", 1'h0, system_reset);
    wr(`RSS_STAT_OFF, 32'h2);
    rd(`RSS_STAT_OFF, 32'h0);
    wr(`RSS_CTRL_OFF, 32'h1);
    $display("test software reset done");
  endtask
  task t_pin;
    power_mode <= RSS_HIBERNATE;
    repeat (3) @(posedge aclk);
    chk("hib mon off", 4'h0, mon_en);
    press <= 1'b1;
    wt(1'b1, n);
    repeat (40) @(posedge aclk);
    chk("pin held", 1'h1, system_reset);
    press <= 1'b0;
    wt(1'b0, n);
    chk("pin stretch", 1'h1, n >= 19);
    power_mode <= RSS_ACTIVE;
    rd(`RSS_STAT_OFF, 32'h1);
    wr(`RSS_STAT_OFF, 32'h1);
    $display("test pin done");
  endtask
  task t_irq;
    wr(`RSS_CTRL_OFF, 32'h9);
    trip.analog_lv <= 1'b1;
    repeat (4) @(posedge aclk);
    chk("alv irq", 1'h1, supply_irq);
    trip.analog_lv <= 1'b0;
    wr(`RSS_STAT_OFF, 32'h8);
    repeat (2) @(posedge aclk);
    chk("irq clear", 1'h0, supply_irq);
    wr(`RSS_CTRL_OFF, 32'h21);
    trip.analog_hv <= 1'b1;
    repeat (4) @(posedge aclk);
    chk("ahv irq", 1'h1, supply_irq);
    trip.analog_hv <= 1'b0;
    wr(`RSS_STAT_OFF, 32'h20);
    wr(`RSS_BUZZ_OFF, 32'hA);
    wr(`RSS_CTRL_OFF, 32'h11);
    power_mode <= RSS_SLEEP;
    trip.core_lv <= 1'b1;
    n = 0;
    while (wake_req !== 1'b1 && n < 40) begin
      @(posedge aclk);
      n++;
    end
    chk("sleep wake", 1'h1, wake_req);
    chk("no irq asleep", 1'h0, supply_irq);
    power_mode <= RSS_ACTIVE;
    repeat (3) @(posedge aclk);
    chk("irq after wake", 1'h1, supply_irq);
    trip.core_lv <= 1'b0;
    wr(`RSS_CTRL_OFF, 32'h81);
    trip.core_lv <= 1'b1;
    wt(1'b1, n);
    trip.core_lv <= 1'b0;
    wt(1'b0, n);
    rd(`RSS_CTRL_OFF, `RSS_CTRL_RST);
    $display("test monitors done");
  endtask
  task t_prec;
    rd(`RSS_STAT_OFF, 32'h10);
    trip.precise_dig <= 1'b1;
    wt(1'b1, n);
    trip.precise_dig <= 1'b0;
    wt(1'b0, n);
    chk("prec stretch", 1'h1, n >= 19);
    rd(`RSS_STAT_OFF, 32'h0);
    $display("test precise done");
  endtask
  task t_wdt;
    wr(`RSS_WDTO_OFF, 32'h40);
    wr(`RSS_CTRL_OFF, 32'h5);
    repeat (3) begin
      repeat (30) @(posedge aclk);
      wr(`RSS_KICK_OFF, 32'h0);
    end
    chk("kicked", 1'h0, system_reset);
    wt(1'b1, n);
    chk("wdt time", 1'h1, n > 50 && n < 80);
    wt(1'b0, n);
    rd(`RSS_STAT_OFF, 32'h4);
    wr(`RSS_CTRL_OFF, 32'h1);
    rd(`RSS_CTRL_OFF, 32'h5);
    $display("test watchdog done");
  endtask
  task t_por;
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    wt(1'b0, n);
    rd(`RSS_STAT_OFF, 32'h0);
    rd(`RSS_CTRL_OFF, `RSS_CTRL_RST);
    $display("test power-on done");
  endtask
  task conclude;
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  initial begin
    aresetn = 1'b0;
    initial_supply_reset = 1'b0;
    supply_ramping = 1'b1;
    press = 1'b0;
    trip = '0;
    power_mode = RSS_ACTIVE;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    s_axi_awaddr = 8'h0;
    s_axi_araddr = 8'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    t_boot;
    t_sw;
    t_pin;
    t_irq;
    t_prec;
    t_wdt;
    t_por;
    conclude;
  end
  initial begin
    #200000;
    n_errors++;
    conclude;
  end
endmodule // system_reset_supervisor_bench
